// File: hw/pstd_decoder.sv
// Target decoder model end: arrival timing, elementary buffers, unit removal
//
// Operation
// - Count time in 27 MHz system ticks
// - Stamp base is ticks div 300
// - Stamp extension is ticks mod 300
// - Full stamp is base times 300 plus extension
// - Stamp marks the stamped base byte arrival
// - Other bytes follow at rate times 50 bytes/s
// - Timing covers header bytes before the stamp
// - Input may idle between packs
// - Payload enters its buffer at arrival time
// - Header bytes never enter elementary buffers
// - Remove oldest unit plus leading stuffing at decode
// - Unstamped units take derived decode times
// - Source keeps buffers within empty and full
// - Underflow tolerated only in low delay or trick
// - Source keeps buffering delay within limits
// - Source never interleaves packs
// - Low delay incomplete unit rechecked every two fields
// - Remove at earliest allowed time, underflow unlimited
// - Single stream uses its own stamp, one buffer
// - Single stream buffer sizes for video and audio
`timescale 1ns/1ps

module pstd_fifo #(
  parameter int W     = 8,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input  wire logic         ref_clk_i,
  input  wire logic         rst_i,
  // Fill side
  input  wire logic         in_valid_i,
  input  wire logic [W-1:0] in_data_i,
  output logic              in_ready_o,
  // Drain side
  output logic              out_valid_o,
  output logic [W-1:0]      out_data_o,
  input  wire logic         out_ready_i
);
  localparam int AW = $clog2(DEPTH);

  logic [W-1:0] mem [DEPTH];
  logic [AW:0]  wr_reg;
  logic [AW:0]  rd_reg;
  logic         push;
  logic         pop;

  assign out_valid_o = wr_reg != rd_reg;
  assign in_ready_o  = (wr_reg[AW] == rd_reg[AW]) || (wr_reg[AW-1:0] != rd_reg[AW-1:0]);
  assign out_data_o  = mem[rd_reg[AW-1:0]];
  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_o && out_ready_i;

  always_ff @(posedge ref_clk_i) begin
    if (push) begin
      mem[wr_reg[AW-1:0]] <= in_data_i;
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      wr_reg <= '0;
      rd_reg <= '0;
    end else begin
      wr_reg <= wr_reg + (AW+1)'(push);
      rd_reg <= rd_reg + (AW+1)'(pop);
    end
  end
endmodule // pstd_fifo

module pstd_decoder #(
  parameter int          NS            = 4,
  parameter int          AU_DEPTH      = 4,
  parameter int          FIFO_DEPTH    = 8,
  parameter int          LEN_W         = 24,
  parameter int unsigned BUF_BYTES     = 65536,
  parameter int unsigned VBV_MAX_BYTES = 229376,
  parameter int unsigned RMAX_BPS      = 15000000
) (
  // Clock and reset
  input  wire logic                    ref_clk_i,
  input  wire logic                    rst_i,
  // Link side
  pstd_link_if.dec                     link,
  // Mode controls
  input  wire logic                    low_delay_i,
  input  wire logic                    trick_i,
  input  wire logic                    single_stream_i,
  input  wire logic                    single_audio_i,
  input  wire logic [42:0]             au_period_i,
  // Status
  output wire logic [NS-1:0]           au_pop_o,
  output wire logic [NS*LEN_W-1:0]     au_bytes_o,
  output wire logic [NS*LEN_W-1:0]     fill_o,
  output wire logic [NS-1:0]           overflow_o,
  output wire logic [NS-1:0]           underflow_o,
  output logic [pstd_pkg::BASE_W-1:0]  time_base_o,
  output logic [pstd_pkg::EXT_W-1:0]   time_ext_o,
  output logic                         synced_o
);
  import pstd_pkg::*;

  localparam int AW = $clog2(AU_DEPTH);
  localparam logic [LEN_W-1:0] CAP_MULTI  = LEN_W'(BUF_BYTES);
  localparam logic [LEN_W-1:0] CAP_AUDIO  = LEN_W'(AUDIO_BUF_BYTES);
  localparam logic [LEN_W-1:0] CAP_VIDEO  = LEN_W'(VBV_MAX_BYTES + RMAX_BPS / (OH_DIV * 8));

  typedef enum logic [1:0] {
    S_RUN  = 2'b00,
    S_DIV1 = 2'b01,
    S_DIV2 = 2'b10
  } pstd_state_e;

  pstd_state_e       st_reg;
  pstd_byte_s        hw;
  logic              hv;
  logic              rel;
  logic              start_div;
  logic [RATE_W-1:0] rate_reg;
  pstd_time_s        scr_reg;
  pstd_time_s        now_reg;
  logic [NUM_W-1:0]  num_reg;
  logic [NUM_W-1:0]  quo_reg;
  logic [RATE_W-1:0] rem_reg;
  logic [PH_W-1:0]   bit_reg;
  logic [NUM_W-1:0]  step_q_reg;
  logic [RATE_W-1:0] step_r_reg;
  logic [TICK_W-1:0] due_t_reg;
  logic [RATE_W-1:0] due_r_reg;
  logic              stamped_reg;
  logic              synced_reg;
  logic [PH_W-1:0]   phase_reg;
  logic [PH_W-1:0]   phase_sum;
  logic              two_tick;

  wire [NUM_W-1:0]  trial    = {rem_reg, num_reg[NUM_W-1]};
  wire              ge       = trial >= {1'b0, rate_reg};
  wire [RATE_W-1:0] rem_nx   = ge ? RATE_W'(trial - {1'b0, rate_reg}) : trial[RATE_W-1:0];
  wire [NUM_W-1:0]  quo_nx   = {quo_reg[NUM_W-2:0], ge};
  wire              div_last = bit_reg == '0;
  wire [TICK_W-1:0] now_lin  = pstd_lin(now_reg);
  wire [TICK_W-1:0] scr_lin  = pstd_lin(scr_reg);
  wire              back_fr  = rem_nx != '0;
  wire [NUM_W-1:0]  r_sum    = {1'b0, due_r_reg} + {1'b0, step_r_reg};
  wire              r_wrap   = r_sum >= {1'b0, rate_reg};
  wire [STREAM_W-1:0] dest   = single_stream_i ? '0 : hw.stream;
  wire [LEN_W-1:0]  cap      = single_stream_i ? (single_audio_i ? CAP_AUDIO : CAP_VIDEO)
                                               : CAP_MULTI;
  wire              tolerate = low_delay_i || trick_i;

  pstd_fifo #(.W($bits(pstd_byte_s)), .DEPTH(FIFO_DEPTH)) u_fifo (
    .ref_clk_i  (ref_clk_i),
    .rst_i      (rst_i),
    .in_valid_i (link.valid),
    .in_data_i  (link.word),
    .in_ready_o (link.ready),
    .out_valid_o(hv),
    .out_data_o (hw),
    .out_ready_i(rel)
  );

  assign phase_sum = phase_reg + PH_STEP;
  assign two_tick  = phase_sum >= PH_MOD;
  // Head byte waits in the FIFO until its arrival time; that stall is the back-pressure
  assign rel       = (st_reg == S_RUN) && hv && synced_reg && (!hw.pack_start || stamped_reg)
                     && (now_lin >= due_t_reg);
  assign start_div = (st_reg == S_RUN) && hv && hw.pack_start && !stamped_reg;
  assign time_base_o = now_reg.base;
  assign time_ext_o  = now_reg.ext;
  assign synced_o    = synced_reg;

  // Local clock; the first stamp seen sets it, later stamps only schedule bytes
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      phase_reg  <= '0;
      now_reg    <= '0;
      synced_reg <= 1'b0;
    end else begin
      phase_reg <= two_tick ? phase_sum - PH_MOD : phase_sum;
      if (st_reg == S_DIV2 && div_last && !synced_reg) begin
        now_reg    <= scr_reg;
        synced_reg <= 1'b1;
      end else begin
        now_reg <= pstd_tick(now_reg, two_tick);
      end
    end
  end

  // Per-byte interval 540000/rate ticks and the 8-byte lead back to pack start,
  // both by one serial divider so no wide divider sits in the byte path
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      st_reg      <= S_RUN;
      rate_reg    <= '0;
      scr_reg     <= '0;
      num_reg     <= '0;
      quo_reg     <= '0;
      rem_reg     <= '0;
      bit_reg     <= '0;
      step_q_reg  <= '0;
      step_r_reg  <= '0;
      due_t_reg   <= '0;
      due_r_reg   <= '0;
      stamped_reg <= 1'b0;
    end else begin
      case (st_reg)
        S_RUN: begin
          if (start_div) begin
            rate_reg <= hw.rate;
            scr_reg  <= hw.clock_reference_stamp;
            num_reg  <= STEP_NUM;
            rem_reg  <= '0;
            bit_reg  <= DIV_LAST;
            st_reg   <= S_DIV1;
          end else if (rel) begin
            due_r_reg <= r_wrap ? RATE_W'(r_sum - {1'b0, rate_reg}) : r_sum[RATE_W-1:0];
            due_t_reg <= due_t_reg + TICK_W'(step_q_reg) + TICK_W'(r_wrap);
            if (hw.pack_start) begin
              stamped_reg <= 1'b0;
            end
          end
        end
        S_DIV1, S_DIV2: begin
          num_reg <= {num_reg[NUM_W-2:0], 1'b0};
          quo_reg <= quo_nx;
          rem_reg <= rem_nx;
          bit_reg <= bit_reg - 5'h01;
          if (div_last && st_reg == S_DIV1) begin
            step_q_reg <= quo_nx;
            step_r_reg <= rem_nx;
            num_reg    <= BACK_NUM;
            rem_reg    <= '0;
            bit_reg    <= DIV_LAST;
            st_reg     <= S_DIV2;
          end else if (div_last) begin
            due_t_reg   <= scr_lin - TICK_W'(quo_nx) - TICK_W'(back_fr);
            due_r_reg   <= back_fr ? rate_reg - rem_nx : '0;
            stamped_reg <= 1'b1;
            st_reg      <= S_RUN;
          end
        end
        default: st_reg <= S_RUN;
      endcase
    end
  end

  // Elementary buffers: byte counts plus a queue of unit sizes and decode times
  for (genvar g = 0; g < NS; g++) begin : g_buf
    logic [LEN_W-1:0]  len_reg [AU_DEPTH];
    logic [TICK_W-1:0] due_reg [AU_DEPTH];
    logic [AW-1:0]     head_reg;
    logic [AW-1:0]     tail_reg;
    logic [AW:0]       cnt_reg;
    logic              open_reg;
    logic [LEN_W-1:0]  stuff_reg;
    logic [LEN_W-1:0]  fill_reg;
    logic [TICK_W-1:0] last_reg;
    logic              pop_reg;
    logic              uf_reg;
    logic              of_reg;
    logic [LEN_W-1:0]  plen_reg;

    wire              hit      = rel && (dest == STREAM_W'(g)) && (hw.kind != KIND_HDR);
    wire              is_pay   = hw.kind == KIND_PAY;
    wire              qfull    = cnt_reg == (AW+1)'(AU_DEPTH);
    wire              push     = hit && is_pay && hw.au_start && !qfull;
    wire              grow     = hit && is_pay && !hw.au_start && open_reg;
    wire [AW-1:0]     newest   = tail_reg - AW'(1);
    wire              complete = (cnt_reg > (AW+1)'(1)) || (cnt_reg != '0 && !open_reg);
    wire              due_hit  = (cnt_reg != '0) && (now_lin >= due_reg[head_reg]);
    wire              pop      = due_hit && complete;
    wire              recheck  = due_hit && !complete;
    wire [TICK_W-1:0] new_due  = hw.has_dts ? {10'h000, hw.decode_stamp} * TICK_W'(EXT_MOD)
                                            : last_reg + au_period_i;
    wire [LEN_W-1:0]  fill_nx  = fill_reg + LEN_W'(hit) - (pop ? len_reg[head_reg] : '0);

    assign au_pop_o[g]                   = pop_reg;
    assign au_bytes_o[g*LEN_W +: LEN_W]  = plen_reg;
    assign fill_o[g*LEN_W +: LEN_W]      = fill_reg;
    assign overflow_o[g]                 = of_reg;
    assign underflow_o[g]                = uf_reg;

    always_ff @(posedge ref_clk_i) begin
      if (push) begin
        len_reg[tail_reg] <= stuff_reg + LEN_W'(1);
        due_reg[tail_reg] <= new_due;
      end else if (grow) begin
        len_reg[newest] <= len_reg[newest] + LEN_W'(1);
      end
      if (recheck) begin
        due_reg[head_reg] <= due_reg[head_reg] + RECHECK_TICKS;
      end
    end

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
        head_reg  <= '0;
        tail_reg  <= '0;
        cnt_reg   <= '0;
        open_reg  <= 1'b0;
        stuff_reg <= '0;
        fill_reg  <= '0;
        last_reg  <= '0;
        pop_reg   <= 1'b0;
        uf_reg    <= 1'b0;
        of_reg    <= 1'b0;
        plen_reg  <= '0;
      end else begin
        fill_reg <= fill_nx;
        of_reg   <= (hit && fill_nx > cap) || (hit && is_pay && hw.au_start && qfull);
        uf_reg   <= recheck && !tolerate;
        pop_reg  <= pop;
        if (pop) begin
          plen_reg <= len_reg[head_reg];
          head_reg <= head_reg + AW'(1);
        end
        cnt_reg <= cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
        if (push) begin
          tail_reg  <= tail_reg + AW'(1);
          last_reg  <= new_due;
          stuff_reg <= '0;
          open_reg  <= !hw.au_last;
        end else if (grow) begin
          open_reg <= !hw.au_last;
        end else if (hit) begin
          // Stuffing and stray payload ride with the next unit
          stuff_reg <= stuff_reg + LEN_W'(1);
        end
      end
    end
  end

endmodule // pstd_decoder

// File: hw/pstd_link_if.sv
// Byte link between the stream source and the target decoder model
`timescale 1ns/1ps
interface pstd_link_if;
  import pstd_pkg::*;

  logic       valid;
  logic       ready;
  pstd_byte_s word;

  modport src (output valid, output word, input ready);
  modport dec (input valid, input word, output ready);
endinterface

// File: hw/pstd_pkg.sv
// Shared constants, types and time helpers for the stream target decoder model
package pstd_pkg;

  localparam int unsigned CLK_HZ    = 25_000_000;
  localparam int unsigned SYS_HZ    = 27_000_000;
  localparam int          BASE_W    = 33;
  localparam int          EXT_W     = 9;
  localparam int          RATE_W    = 22;
  localparam int          TICK_W    = 43;
  localparam int          STREAM_W  = 2;
  localparam int          NUM_W     = 23;
  localparam int          PH_W      = 5;
  // Local clock phase: each ref cycle adds SYS_HZ/CLK_HZ system ticks
  localparam logic [PH_W-1:0]   PH_MOD  = PH_W'(CLK_HZ / 1_000_000);
  localparam logic [PH_W-1:0]   PH_STEP = PH_W'((SYS_HZ - CLK_HZ) / 1_000_000);
  localparam logic [EXT_W-1:0]  EXT_MOD = 9'h12C;
  localparam int unsigned       RATE_UNIT      = 50;
  localparam int unsigned       STAMP_BYTE_OFS = 8;
  localparam logic [NUM_W-1:0]  STEP_NUM = NUM_W'(SYS_HZ / RATE_UNIT);
  localparam logic [NUM_W-1:0]  BACK_NUM = NUM_W'(SYS_HZ / RATE_UNIT * STAMP_BYTE_OFS);
  localparam logic [PH_W-1:0]   DIV_LAST = PH_W'(NUM_W - 1);
  localparam longint unsigned   FIELD_PERIOD_NS = 20_000_000;
  localparam logic [TICK_W-1:0] RECHECK_TICKS =
    TICK_W'(64'h2 * FIELD_PERIOD_NS * SYS_HZ / 1_000_000_000);
  localparam int unsigned       AUDIO_BUF_BYTES = 2848;
  localparam int unsigned       OH_DIV          = 750;

  typedef enum logic [1:0] {
    KIND_HDR   = 2'h0,
    KIND_PAY   = 2'h1,
    KIND_STUFF = 2'h2
  } pstd_kind_e;

  typedef struct packed {
    logic [BASE_W-1:0] base;
    logic [EXT_W-1:0]  ext;
  } pstd_time_s;

  typedef struct packed {
    logic [7:0]          data;
    pstd_kind_e          kind;
    logic                pack_start;
    logic                au_start;
    logic                au_last;
    logic                has_dts;
    logic [BASE_W-1:0]   decode_stamp;
    logic [STREAM_W-1:0] stream;
    pstd_time_s          clock_reference_stamp;
    logic [RATE_W-1:0]   rate;
  } pstd_byte_s;

  // Advance a split base/extension clock by one or two system ticks
  function automatic pstd_time_s pstd_tick(input pstd_time_s t, input logic two);
    pstd_time_s       r;
    logic [EXT_W:0]   s;
    r = t;
    s = {1'b0, t.ext} + (two ? 10'h002 : 10'h001);
    if (s >= {1'b0, EXT_MOD}) begin
      r.ext  = EXT_W'(s - {1'b0, EXT_MOD});
      r.base = t.base + 33'h1;
    end else begin
      r.ext = s[EXT_W-1:0];
    end
    return r;
  endfunction

  // Linear time in system ticks: base times 300 plus extension
  function automatic logic [TICK_W-1:0] pstd_lin(input pstd_time_s t);
    return ({10'h000, t.base} * TICK_W'(EXT_MOD)) + TICK_W'(t.ext);
  endfunction

endpackage

// File: hw/pstd_source.sv
// Stream source end: forwards pack bytes in order, optionally stamps packs
`timescale 1ns/1ps
module pstd_source (
  // Clock and reset
  input  wire logic                ref_clk_i,
  input  wire logic                rst_i,
  // User side
  input  wire logic                in_valid_i,
  input  wire pstd_pkg::pstd_byte_s in_word_i,
  input  wire logic                auto_stamp_i,
  output logic                     in_ready_o,
  // Link side
  pstd_link_if.src                 link
);
  import pstd_pkg::*;

  logic              valid_reg;
  pstd_byte_s        word_reg;
  pstd_byte_s        word_next;
  pstd_time_s        now_reg;
  logic [PH_W-1:0]   phase_reg;
  logic [PH_W-1:0]   phase_sum;
  logic              two_tick;
  logic              load;

  assign phase_sum  = phase_reg + PH_STEP;
  assign two_tick   = phase_sum >= PH_MOD;
  // A slot frees when the decoder takes the byte; its FIFO back-pressure stalls us
  assign load       = !valid_reg || link.ready;
  assign in_ready_o = load;
  assign link.valid = valid_reg;
  assign link.word  = word_reg;

  always_comb begin
    word_next = in_word_i;
    if (auto_stamp_i && in_word_i.pack_start) begin
      word_next.clock_reference_stamp = now_reg;
    end
  end

  // Own clock is kept as base and extension directly
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      phase_reg <= '0;
      now_reg   <= '0;
    end else begin
      phase_reg <= two_tick ? phase_sum - PH_MOD : phase_sum;
      now_reg   <= pstd_tick(now_reg, two_tick);
    end
  end

  // Bytes leave strictly in user order; gaps between packs are allowed
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      valid_reg <= 1'b0;
      word_reg  <= '0;
    end else if (load) begin
      valid_reg <= in_valid_i;
      word_reg  <= word_next;
    end
  end

endmodule // pstd_source

// File: verif/pstd_bench.sv
// Bench joining the stream source and the target decoder model
`timescale 1ns/1ps
module pstd_bench;
  import pstd_pkg::*;
  logic              ref_clk_i;
  logic              rst_i;
  logic              in_valid_i;
  logic              auto_stamp_i;
  logic              in_ready_o;
  logic              low_delay_i;
  logic              trick_i;
  logic              single_stream_i;
  pstd_byte_s        in_word_i;
  logic [3:0]        au_pop_o;
  logic [95:0]       au_bytes_o;
  logic [95:0]       fill_o;
  logic [3:0]        overflow_o;
  logic [3:0]        underflow_o;
  logic [3:0]        of_seen;
  logic [3:0]        uf_seen;
  logic [23:0]       f1_prev;
  logic [BASE_W-1:0] time_base_o;
  logic [EXT_W-1:0]  time_ext_o;
  logic              synced_o;
  int                miscompares;
  int                num_checks;
  int                nrdy;
  int                exp_fill[4];
  longint            scr_v;
  longint            rate_v;
  longint            fq_t[$];
  longint            fq_v[$];
  longint            pq_t[$];
  longint            pq_v[$];
  pstd_byte_s        q[$];

  pstd_link_if pstd_link_if_inst ();

  pstd_source pstd_source_inst (
    .ref_clk_i    (ref_clk_i),
    .rst_i        (rst_i),
    .in_valid_i   (in_valid_i),
    .in_word_i    (in_word_i),
    .auto_stamp_i (auto_stamp_i),
    .in_ready_o   (in_ready_o),
    .link         (pstd_link_if_inst.src)
  );

  pstd_decoder pstd_decoder_inst (
    .ref_clk_i       (ref_clk_i),
    .rst_i           (rst_i),
    .link            (pstd_link_if_inst.dec),
    .low_delay_i     (low_delay_i),
    .trick_i         (trick_i),
    .single_stream_i (single_stream_i),
    .single_audio_i  (1'b0),
    .au_period_i     (43'h258),
    .au_pop_o        (au_pop_o),
    .au_bytes_o      (au_bytes_o),
    .fill_o          (fill_o),
    .overflow_o      (overflow_o),
    .underflow_o     (underflow_o),
    .time_base_o     (time_base_o),
    .time_ext_o      (time_ext_o),
    .synced_o        (synced_o)
  );

  pstd_chk pstd_chk_inst (
    .ref_clk_i (ref_clk_i),
    .rst_i     (rst_i),
    .valid     (pstd_link_if_inst.valid),
    .ready     (pstd_link_if_inst.ready),
    .word      (pstd_link_if_inst.word)
  );

  initial begin
    ref_clk_i = 1'b0;
    forever #20 ref_clk_i = ~ref_clk_i;
  end

  function automatic pstd_time_s split(longint v);
    pstd_time_s t;
    t.base = BASE_W'(v / 300);
    t.ext  = EXT_W'(v % 300);
    return t;
  endfunction

  function automatic longint now_t();
    return longint'(time_base_o) * 300 + longint'(time_ext_o);
  endfunction

  // Late by up to a few ticks: release and the fill update are registered
  function automatic logic inwin(longint t, longint due);
    return t >= due && t <= due + 6;
  endfunction

  // Flags are pack_start, au_start, au_last, has_dts
  function automatic pstd_byte_s mk(pstd_kind_e k, int s, logic [3:0] f, longint d);
    pstd_byte_s w;
    w = '0;
    w.data = 8'($urandom);
    w.kind = k;
    w.stream = 2'(s);
    {w.pack_start, w.au_start, w.au_last, w.has_dts} = f;
    w.decode_stamp = 33'(d);
    w.clock_reference_stamp = split(scr_v);
    w.rate = 22'(rate_v);
    return w;
  endfunction

  always @(negedge ref_clk_i) begin
    if (fill_o[47:24] !== f1_prev) begin
      fq_t.push_back(now_t());
      fq_v.push_back(longint'(fill_o[47:24]));
    end
    f1_prev = fill_o[47:24];
    if (au_pop_o[1] === 1'b1) begin
      pq_t.push_back(now_t());
      pq_v.push_back(longint'(au_bytes_o[47:24]));
    end
    of_seen = of_seen | overflow_o;
    uf_seen = uf_seen | underflow_o;
    if (pstd_link_if_inst.ready === 1'b0) nrdy++;
  end

  task automatic check(string name, logic [63:0] seen, logic [63:0] exp);
    num_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch %s expected %0h seen %0h", name, exp, seen);
    end
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic timeout();
    miscompares++;
    end_of_test();
  endtask

  // Bytes are held on the link until taken, never dropped
  task automatic send();
    int n;
    foreach (q[k]) begin
      in_word_i = q[k];
      in_valid_i = 1'b1;
      for (n = 0; n < 30000 && in_ready_o !== 1'b1; n++) @(negedge ref_clk_i);
      if (n == 30000) timeout();
      @(negedge ref_clk_i);
    end
    in_valid_i = 1'b0;
    q.delete();
  endtask

  task automatic wait_fill(int s);
    int n;
    for (n = 0; n < 3000 && fill_o[s*24+:24] !== 24'(exp_fill[s]); n++) @(negedge ref_clk_i);
    check("fill", fill_o[s*24+:24], 24'(exp_fill[s]));
    if (n == 3000) timeout();
  endtask

  task automatic pack_hdr();
    q.push_back(mk(KIND_HDR, 0, 4'h8, 0));
    repeat (7) q.push_back(mk(KIND_HDR, 0, 4'h0, 0));
  endtask

  initial begin
    longint     t0;
    longint     dd;
    int         s;
    pstd_kind_e k;
    rst_i = 1'b1;
    in_valid_i = 1'b0;
    in_word_i = '0;
    auto_stamp_i = 1'b1;
    low_delay_i = 1'b0;
    trick_i = 1'b0;
    single_stream_i = 1'b0;
    f1_prev = '0;
    of_seen = '0;
    uf_seen = '0;
    exp_fill = '{default: 0};
    void'($urandom(32'h2f93));
    repeat (5) @(negedge ref_clk_i);
    rst_i = 1'b0;
    // Let the source clock run past the pre-stamp lead so no due time wraps below zero
    repeat (10) @(negedge ref_clk_i);
    // First pack: source stamps it, random byte kinds on streams 0 and 3
    scr_v = 0;
    rate_v = 4000000;
    pack_hdr();
    repeat ($urandom_range(12, 4)) begin
      k = pstd_kind_e'($urandom % 3);
      s = ($urandom % 2) * 3;
      q.push_back(mk(k, s, 4'h0, 0));
      if (k != KIND_HDR) exp_fill[s]++;
    end
    send();
    for (int n = 0; n < 3000 && synced_o !== 1'b1; n++) @(negedge ref_clk_i);
    check("synced", synced_o, 1'b1);
    wait_fill(0);
    wait_fill(3);
    t0 = now_t();
    repeat (250) @(negedge ref_clk_i);
    check("ticks", now_t() - t0, 270);
    check("ext_range", time_ext_o < 300, 1'b1);
    // Slow pack: 100 ticks a byte, stuffing before the stamped byte
    auto_stamp_i = 1'b0;
    scr_v = now_t() + 20000;
    rate_v = 5400;
    dd = scr_v / 300 + 5;
    fq_t.delete();
    fq_v.delete();
    pack_hdr();
    q[6] = mk(KIND_STUFF, 1, 4'h0, 0);
    q.push_back(mk(KIND_PAY, 1, 4'h5, dd));
    q.push_back(mk(KIND_PAY, 1, 4'h0, 0));
    q.push_back(mk(KIND_PAY, 1, 4'h2, 0));
    q.push_back(mk(KIND_PAY, 1, 4'h6, 0));
    send();
    for (int n = 0; n < 5000 && pq_t.size() < 2; n++) @(negedge ref_clk_i);
    if (pq_t.size() < 2) timeout();
    check("pre_stamp", inwin(fq_t[0], scr_v - 200), 1'b1);
    for (int j = 1; j < 5; j++) begin
      check("fill_val", fq_v[j], j + 1);
      check("fill_time", inwin(fq_t[j], scr_v + (j - 1) * 100), 1'b1);
    end
    check("pop_time", inwin(pq_t[0], dd * 300), 1'b1);
    check("pop_bytes", pq_v[0], 4);
    check("next_time", inwin(pq_t[1], dd * 300 + 600), 1'b1);
    check("next_bytes", pq_v[1], 1);
    wait_fill(1);
    check("link_stall", nrdy > 0, 1'b1);
    // Incomplete unit at its decode time, refused then tolerated
    rate_v = 4000000;
    for (int ld = 0; ld < 3; ld++) begin
      s = (ld == 2) ? 1 : 2 + ld;
      low_delay_i = (ld == 1);
      trick_i = (ld == 2);
      scr_v = now_t() + 2000;
      pack_hdr();
      q.push_back(mk(KIND_PAY, s, 4'h5, scr_v / 300));
      send();
      exp_fill[s]++;
      wait_fill(s);
      for (int n = 0; n < 3000 && uf_seen[s] !== 1'b1; n++) @(negedge ref_clk_i);
      check("underflow", uf_seen[s], ld == 0);
    end
    low_delay_i = 1'b0;
    trick_i = 1'b0;
    // Single stream: all payload bytes land in buffer 0, fifth unit overruns the queue
    single_stream_i = 1'b1;
    scr_v = now_t() + 1000;
    pack_hdr();
    repeat (5) q.push_back(mk(KIND_PAY, 3, 4'h7, scr_v / 300 + 99999));
    exp_fill[0] += 5;
    send();
    wait_fill(0);
    for (int n = 0; n < 300 && of_seen[0] !== 1'b1; n++) @(negedge ref_clk_i);
    check("queue_full", of_seen[0], 1'b1);
    wait_fill(3);
    end_of_test();
  end
endmodule // pstd_bench

// File: verif/pstd_chk.sv
// Link checker for the byte link between source and decoder model
`timescale 1ns/1ps
module pstd_chk (
  // Clock and reset
  input  wire logic                ref_clk_i,
  input  wire logic                rst_i,
  // Link signals
  input  wire logic                valid,
  input  wire logic                ready,
  input  wire pstd_pkg::pstd_byte_s word
);
  import pstd_pkg::*;

  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (rst_i);

  chk_valid_held: assert property (valid && !ready |=> valid)
    else $error("link valid dropped before taken");
  chk_word_held: assert property (valid && !ready |=> $stable(word))
    else $error("link word changed while waiting");
  chk_ext_range: assert property (valid && word.pack_start |-> word.clock_reference_stamp.ext < EXT_MOD)
    else $error("stamp extension out of range");
  chk_rate_legal: assert property (valid && word.pack_start |-> word.rate != '0)
    else $error("pack arrival rate is zero");
  chk_stamp_in_hdr: assert property (valid && word.pack_start |-> word.kind == KIND_HDR)
    else $error("pack start byte not a header byte");
  chk_hdr_no_unit: assert property (
    valid && word.kind == KIND_HDR |-> !(word.au_start || word.au_last))
    else $error("header byte marks a unit boundary");
  chk_dts_on_start: assert property (valid && word.has_dts |-> word.au_start)
    else $error("decode stamp away from unit start");
  chk_kind_legal: assert property (valid |-> word.kind != 2'h3)
    else $error("unknown byte kind on link");
endmodule // pstd_chk
